// File: pkg/mcd_core_defines.vh
// Constants and field layout of the execution core
// Overview of operation
// - 23-bit PC reaching 4M program words
// - 24-bit instruction words, fixed 4-bit opcode field
// - Next instruction fetched one cycle ahead
// - Single cycle except flow changes
// - Zero-overhead repeat, interruptible every iteration
// - Sixteen 16-bit data/pointer/offset registers
// - Last register is the stack pointer
// - Linear 64-Kbyte byte-addressed data space
// - Upper 32 Kbytes map onto program pages
// - Six addressing modes from predefined groups
// - Read, register read, write, fetch per cycle
// - Single-cycle 17x17 multiplier, all sign mixes
// - Iterative divide, repeat loop, 18 cycles
// - Interrupted divide keeps partial results
// - 40-bit shifter, up to 16 places
// - Stack post-increments on push, pre-decrements pop
// - Odd word address traps, no access, except an odd SP, which the exception push still writes
// - Byte op changes only low byte of a register, addressed byte lane in memory
`ifndef MCD_CORE_DEFINES_VH
`define MCD_CORE_DEFINES_VH
`define MCD_F_OP     23:20
`define MCD_F_SUB    19:16
`define MCD_F_BYTE   15
`define MCD_F_WD     14:11
`define MCD_F_WB     10:7
`define MCD_F_WS     6:3
`define MCD_F_DIND   2
`define MCD_F_SMODE  1:0
`define MCD_F_LIT    15:0
`define MCD_F_RPT    13:0
`define MCD_F_SAMT   17:13
`define MCD_OP_ALU   4'h0
`define MCD_OP_LIT   4'h1
`define MCD_OP_LDD   4'h2
`define MCD_OP_STD   4'h3
`define MCD_OP_BRA   4'h4
`define MCD_OP_CALL  4'h5
`define MCD_OP_RET   4'h6
`define MCD_OP_RPT   4'h7
`define MCD_OP_MUL   4'h8
`define MCD_OP_DIV   4'h9
`define MCD_OP_SHF   4'ha
`define MCD_ALU_ADD  3'h0
`define MCD_ALU_SUB  3'h1
`define MCD_ALU_AND  3'h2
`define MCD_ALU_IOR  3'h3
`define MCD_ALU_XOR  3'h4
`define MCD_ALU_MOV  3'h5
`define MCD_REG_PVP  12'h000
`define MCD_REG_CTRL 12'h004
`define MCD_REG_PC   12'h008
`define MCD_REG_STAT 12'h00c
`define MCD_CTRL_PSV 0
`define MCD_CTRL_RUN 1
`define MCD_PVP_RESET  8'h00
`define MCD_RESET_PC   23'h000000
`define MCD_INT_VECTOR 23'h000004
`define MCD_TRAP_VECTOR 23'h000008
`define MCD_RESET_SP   16'h0800
`define MCD_DIV_LAST   5'h11
`define MCD_SHIFT_MAX  5'h10
`endif

// File: verilog/mcd_core.v
// Execution core: prefetch, decode, registers, arithmetic units, APB
`include "mcd_core_defines.vh"
module mcd_core (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [22:0] prog_addr,
    input  wire [23:0] prog_rdata,
    output wire [22:0] psv_addr,
    input  wire [23:0] psv_rdata,
    output reg  [15:0] dmem_raddr,
    input  wire [15:0] dmem_rdata,
    output reg  [15:0] dmem_waddr,
    output reg  [15:0] dmem_wdata,
    output reg         dmem_we,
    output reg  [1:0]  dmem_wbe,
    input  wire        irq_req,
    output reg         irq_ack,
    output reg         addr_error
);
    localparam ST_EXEC  = 2'h0;
    localparam ST_PUSH2 = 2'h1;
    localparam ST_POP2  = 2'h2;

    reg  [15:0] wreg [0:15];
    reg  [23:0] ir;
    reg  [22:0] ir_pc;
    reg         ir_valid;
    reg  [1:0]  state;
    reg  [13:0] rcount;
    reg         rpt_active;
    reg         flag_z;
    reg         flag_n;
    reg         flag_c;
    reg  [7:0]  program_visibility_page;
    reg         psv_en;
    reg         core_run;
    reg  [15:0] tmp_word;
    reg  [22:0] jump_pc;
    reg  [4:0]  div_step;
    reg  [15:0] div_rem;
    reg  [15:0] div_acc;
    reg  [15:0] div_dsr;
    reg         div_neg_q;
    reg         div_neg_r;
    integer     i;

    function [31:0] mcd_cneg;
        input [31:0] v;
        input        n;
        begin
            mcd_cneg = n ? (~v + 32'h00000001) : v;
        end
    endfunction

    wire [3:0]  op      = ir[`MCD_F_OP];
    wire [2:0]  alu_fn  = ir[18:16];
    wire [3:0]  wl      = ir[`MCD_F_SUB];
    wire [3:0]  wd      = ir[`MCD_F_WD];
    wire [3:0]  wb      = ir[`MCD_F_WB];
    wire [3:0]  ws      = ir[`MCD_F_WS];
    wire [3:0]  wd1     = wd + 4'h1;
    wire [3:0]  wb1     = wb + 4'h1;
    wire [3:0]  ws1     = ws + 4'h1;
    wire        byte_op = ir[`MCD_F_BYTE];
    wire        dind    = ir[`MCD_F_DIND];
    wire [1:0]  smode   = ir[`MCD_F_SMODE];
    wire [15:0] sp      = wreg[15];
    wire [15:0] ea_step = byte_op ? 16'h0001 : 16'h0002;
    wire [15:0] ea_src  = (smode == 2'h3) ? wreg[ws] - ea_step : wreg[ws];
    wire        is_alu  = (op == `MCD_OP_ALU);
    wire        is_ret  = (op == `MCD_OP_RET);
    wire        is_call = (op == `MCD_OP_CALL);

    // Odd word addresses trap; only an odd SP still reaches memory, written by the exception push
    wire misalign = (is_alu & ~byte_op &
                     (((smode != 2'h0) & ea_src[0]) | (dind & wreg[wd][0])))
                  | (((op == `MCD_OP_LDD) | (op == `MCD_OP_STD)) & ir[0])
                  | ((is_call | is_ret) & sp[0]);

    wire exec     = core_run & (state == ST_EXEC);
    wire trap     = exec & ir_valid & misalign;
    wire take_irq = exec & ir_valid & ~misalign & irq_req;
    wire exc      = trap | take_irq;
    wire run_ins  = exec & ir_valid & ~exc;
    wire hold     = run_ins & rpt_active & (rcount != 14'h0000);

    reg         cond_ok;
    always @*
    begin
        case (wl)
            4'h0:    cond_ok = 1'b1;
            4'h1:    cond_ok = flag_z;
            4'h2:    cond_ok = ~flag_z;
            4'h3:    cond_ok = flag_c;
            4'h4:    cond_ok = ~flag_c;
            4'h5:    cond_ok = flag_n;
            default: cond_ok = 1'b0;
        endcase
    end

    wire [22:0] bra_tgt = ir_pc + 23'h000002 +
                          {{6{ir[15]}}, ir[`MCD_F_LIT], 1'b0};
    wire [22:0] ret_pc  = (is_call & ~exc) ? ir_pc + 23'h000002 : ir_pc;
    wire        bra_go  = run_ins & (op == `MCD_OP_BRA) & cond_ok;
    wire        do_jump = bra_go | (core_run & (state != ST_EXEC));
    wire        advance = exec & (~ir_valid | (run_ins & ~hold & ~bra_go &
                          ~is_call & ~is_ret));

    // Data read path, program-visible window in the upper half
    wire        rd_psv  = psv_en & dmem_raddr[15];
    wire [15:0] rd_raw  = rd_psv ? psv_rdata[15:0] : dmem_rdata;
    wire        rd_byte = is_alu & byte_op;
    wire [15:0] rd_word = ~rd_byte ? rd_raw :
                          dmem_raddr[0] ? {8'h00, rd_raw[15:8]} :
                          {8'h00, rd_raw[7:0]};
    assign psv_addr = {program_visibility_page, dmem_raddr[14:1], 1'b0};

    always @*
    begin
        if ((state == ST_POP2) | is_ret)
            dmem_raddr = sp - 16'h0002;
        else if (op == `MCD_OP_LDD)
            dmem_raddr = ir[`MCD_F_LIT];
        else
            dmem_raddr = ea_src;
    end

    // ALU: result = source op wb, source register or memory
    wire [15:0] opa     = (smode == 2'h0) ? wreg[ws] : rd_word;
    wire [15:0] opb     = (alu_fn == `MCD_ALU_SUB) ? ~wreg[wb] : wreg[wb];
    wire [16:0] alu_sum = {1'b0, opa} + {1'b0, opb} +
                          {16'h0000, alu_fn == `MCD_ALU_SUB};
    reg  [16:0] alu_r;
    always @*
    begin
        case (alu_fn)
            `MCD_ALU_ADD: alu_r = alu_sum;
            `MCD_ALU_SUB: alu_r = alu_sum;
            `MCD_ALU_AND: alu_r = {1'b0, opa & wreg[wb]};
            `MCD_ALU_IOR: alu_r = {1'b0, opa | wreg[wb]};
            `MCD_ALU_XOR: alu_r = {1'b0, opa ^ wreg[wb]};
            default:      alu_r = {1'b0, opa};
        endcase
    end
    wire alu_z = byte_op ? (alu_r[7:0] == 8'h00) : (alu_r[15:0] == 16'h0000);
    wire alu_n = byte_op ? alu_r[7] : alu_r[15];
    wire alu_c = byte_op ? (alu_r[8] ^ opa[8] ^ opb[8]) : alu_r[16];

    // Multiplier
    wire signed [16:0] mul_a = {ir[19] & wreg[ws][15], wreg[ws]};
    wire signed [16:0] mul_b = {ir[18] & wreg[wb][15], wreg[wb]};
    wire signed [33:0] mul_p = mul_a * mul_b;

    // Shifter, upper byte extends the sign for arithmetic right shifts
    wire [4:0]  shf_amt = (ir[`MCD_F_SAMT] > `MCD_SHIFT_MAX) ?
                          `MCD_SHIFT_MAX : ir[`MCD_F_SAMT];
    wire [39:0] shf_in  = {{8{ir[18] & wreg[ws1][15]}}, wreg[ws1], wreg[ws]};
    wire signed [39:0] shf_s = shf_in;
    wire [39:0] shf_ar  = shf_s >>> shf_amt;
    wire [39:0] shf_out = ~ir[19] ? (shf_in << shf_amt) :
                          ir[18] ? shf_ar : (shf_in >> shf_amt);

    // Divider operands and one restoring step
    wire        div_sg  = ir[19];
    wire [31:0] div_d32 = ir[18] ? {wreg[wb1], wreg[wb]} :
                          ir[17] ? {wreg[wb], 16'h0000} :
                          {{16{div_sg & wreg[wb][15]}}, wreg[wb]};
    wire [31:0] div_mag = mcd_cneg(div_d32, div_sg & div_d32[31]);
    wire [31:0] div_vm  = mcd_cneg({16'h0000, wreg[ws]},
                                   div_sg & wreg[ws][15]);
    wire [16:0] div_rs  = {div_rem, div_acc[15]};
    wire        div_ge  = div_rs >= {1'b0, div_dsr};
    wire [16:0] div_sub = div_rs - {1'b0, div_dsr};
    wire [31:0] div_q   = mcd_cneg({16'h0000, div_acc}, div_neg_q);
    wire [31:0] div_r   = mcd_cneg({16'h0000, div_rem}, div_neg_r);

    // Data write port, used in the same cycle as the read
    always @*
    begin
        dmem_we    = 1'b0;
        dmem_waddr = sp;
        dmem_wdata = ret_pc[15:0];
        dmem_wbe   = 2'h3;
        if (exc | (core_run & (state == ST_PUSH2)) | (run_ins & is_call))
        begin
            dmem_we = 1'b1;
            if (state == ST_PUSH2)
                dmem_wdata = tmp_word;
        end
        else if (run_ins & (op == `MCD_OP_STD))
        begin
            dmem_we    = 1'b1;
            dmem_waddr = ir[`MCD_F_LIT];
            dmem_wdata = wreg[wl];
        end
        else if (run_ins & is_alu & dind)
        begin
            dmem_we    = 1'b1;
            dmem_waddr = wreg[wd];
            dmem_wdata = byte_op ? {alu_r[7:0], alu_r[7:0]} : alu_r[15:0];
            if (byte_op)
                dmem_wbe = wreg[wd][0] ? 2'h2 : 2'h1;
        end
        // Program window is read only from the data side
        if (psv_en & dmem_waddr[15])
            dmem_we = 1'b0;
    end

    // Fetch stage runs one instruction ahead of execute
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prog_addr <= `MCD_RESET_PC;
            ir        <= 24'h000000;
            ir_pc     <= `MCD_RESET_PC;
            ir_valid  <= 1'b0;
        end
        else if (do_jump)
        begin
            prog_addr <= (state == ST_PUSH2) ? jump_pc :
                         (state == ST_POP2) ?
                         {tmp_word[6:0], rd_raw[15:1], 1'b0} : bra_tgt;
            ir_valid  <= 1'b0;
        end
        else if (advance)
        begin
            ir        <= prog_rdata;
            ir_pc     <= prog_addr;
            prog_addr <= prog_addr + 23'h000002;
            ir_valid  <= 1'b1;
        end
    end

    // Execute stage, register file and control state
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (i = 0; i < 15; i = i + 1)
                wreg[i] <= 16'h0000;
            wreg[15]   <= `MCD_RESET_SP;
            state      <= ST_EXEC;
            rcount     <= 14'h0000;
            rpt_active <= 1'b0;
            flag_z     <= 1'b0;
            flag_n     <= 1'b0;
            flag_c     <= 1'b0;
            tmp_word   <= 16'h0000;
            jump_pc    <= `MCD_RESET_PC;
            div_step   <= 5'h00;
            div_rem    <= 16'h0000;
            div_acc    <= 16'h0000;
            div_dsr    <= 16'h0000;
            div_neg_q  <= 1'b0;
            div_neg_r  <= 1'b0;
            irq_ack    <= 1'b0;
            addr_error <= 1'b0;
            program_visibility_page <= `MCD_PVP_RESET;
            psv_en     <= 1'b0;
            core_run   <= 1'b0;
        end
        else
        begin
            irq_ack    <= take_irq;
            addr_error <= trap;
            if (psel & penable & pwrite & (paddr == `MCD_REG_PVP))
                program_visibility_page <= pwdata[7:0];
            if (psel & penable & pwrite & (paddr == `MCD_REG_CTRL))
            begin
                psv_en   <= pwdata[`MCD_CTRL_PSV];
                core_run <= pwdata[`MCD_CTRL_RUN];
            end
            if (exc | (run_ins & is_call))
            begin
                // Repeat state rides on the stack so the loop resumes
                wreg[15]   <= sp + 16'h0002;
                tmp_word   <= {rpt_active, 8'h00, ret_pc[22:16]};
                jump_pc    <= trap ? `MCD_TRAP_VECTOR :
                              take_irq ? `MCD_INT_VECTOR : bra_tgt;
                rpt_active <= 1'b0;
                state      <= ST_PUSH2;
            end
            else if (core_run & (state == ST_PUSH2))
            begin
                wreg[15] <= sp + 16'h0002;
                state    <= ST_EXEC;
            end
            else if (core_run & (state == ST_POP2))
            begin
                wreg[15]   <= sp - 16'h0002;
                rpt_active <= tmp_word[15];
                state      <= ST_EXEC;
            end
            else if (run_ins)
            begin
                if (rpt_active)
                begin
                    if (rcount != 14'h0000)
                        rcount <= rcount - 14'h0001;
                    else
                        rpt_active <= 1'b0;
                end
                case (op)
                    `MCD_OP_ALU:
                    begin
                        if (smode == 2'h2)
                            wreg[ws] <= wreg[ws] + ea_step;
                        else if (smode == 2'h3)
                            wreg[ws] <= ea_src;
                        if (!dind)
                            wreg[wd] <= byte_op ?
                                {wreg[wd][15:8], alu_r[7:0]} :
                                alu_r[15:0];
                        flag_z <= alu_z;
                        flag_n <= alu_n;
                        flag_c <= alu_c;
                    end
                    `MCD_OP_LIT:
                        wreg[wl] <= ir[`MCD_F_LIT];
                    `MCD_OP_LDD:
                        wreg[wl] <= rd_word;
                    `MCD_OP_RPT:
                    begin
                        rcount     <= ir[`MCD_F_RPT];
                        rpt_active <= (ir[`MCD_F_RPT] != 14'h0000);
                    end
                    `MCD_OP_MUL:
                    begin
                        wreg[wd]  <= mul_p[15:0];
                        wreg[wd1] <= mul_p[31:16];
                    end
                    `MCD_OP_SHF:
                    begin
                        wreg[wd]  <= shf_out[15:0];
                        wreg[wd1] <= shf_out[31:16];
                    end
                    `MCD_OP_DIV:
                    begin
                        // State lives apart from the register file
                        if (div_step == 5'h00)
                        begin
                            div_rem   <= div_mag[31:16];
                            div_acc   <= div_mag[15:0];
                            div_dsr   <= div_vm[15:0];
                            div_neg_q <= div_sg & (div_d32[31] ^ wreg[ws][15]);
                            div_neg_r <= div_sg & div_d32[31];
                        end
                        else if (div_step == `MCD_DIV_LAST)
                        begin
                            wreg[0] <= div_q[15:0];
                            wreg[1] <= div_r[15:0];
                        end
                        else
                        begin
                            div_rem <= div_ge ? div_sub[15:0] : div_rs[15:0];
                            div_acc <= {div_acc[14:0], div_ge};
                        end
                        div_step <= (div_step == `MCD_DIV_LAST) ? 5'h00 :
                                    div_step + 5'h01;
                    end
                    `MCD_OP_RET:
                    begin
                        wreg[15] <= sp - 16'h0002;
                        tmp_word <= rd_raw;
                        state    <= ST_POP2;
                    end
                    default:
                        state <= ST_EXEC;
                endcase
            end
        end
    end

    // APB slave, zero wait states, read data captured in the setup cycle, write data in the access cycle
    wire apb_hit = (paddr == `MCD_REG_PVP) | (paddr == `MCD_REG_CTRL) |
                   (paddr == `MCD_REG_PC) | (paddr == `MCD_REG_STAT);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~apb_hit;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel & ~penable)
        begin
            case (paddr)
                `MCD_REG_PVP:  prdata <= {24'h000000, program_visibility_page};
                `MCD_REG_CTRL: prdata <= {30'h00000000, core_run, psv_en};
                `MCD_REG_PC:   prdata <= {9'h000, ir_pc};
                `MCD_REG_STAT: prdata <= {12'h000, rcount, state, rpt_active,
                                          flag_c, flag_n, flag_z};
                default:       prdata <= 32'h00000000;
            endcase
        end
    end
endmodule // mcd_core

// File: tb/mcd_core_chk.sv
// Port-level assertions for the execution core
`include "mcd_core_defines.vh"
module mcd_core_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [22:0] prog_addr,
    input wire logic [22:0] psv_addr,
    input wire logic [15:0] dmem_raddr,
    input wire logic [15:0] dmem_waddr,
    input wire logic        dmem_we,
    input wire logic [1:0]  dmem_wbe,
    input wire logic        addr_error
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_fetch_even;
        prog_addr[0] == 1'b0;
    endproperty
    a_fetch_even: assert property (p_fetch_even)
        else $error("fetch address odd");
    // Any jump must be followed by a plain sequential fetch
    property p_jump_refetch;
        (prog_addr != $past(prog_addr) && prog_addr != $past(prog_addr) + 23'h2)
        |=> prog_addr == $past(prog_addr) + 23'h2;
    endproperty
    a_jump_refetch: assert property (p_jump_refetch)
        else $error("no sequential fetch after jump");
    property p_psv_map;
        dmem_raddr[15] |-> psv_addr[14:0] == {dmem_raddr[14:1], 1'b0};
    endproperty
    a_psv_map: assert property (p_psv_map)
        else $error("visibility address wrong");
    property p_we_aligned;
        (dmem_we && dmem_wbe == 2'b11) |-> !dmem_waddr[0];
    endproperty
    a_we_aligned: assert property (p_we_aligned)
        else $error("odd word write");
    property p_byte_lane;
        (dmem_we && dmem_wbe != 2'b11)
        |-> dmem_wbe == (dmem_waddr[0] ? 2'b10 : 2'b01);
    endproperty
    a_byte_lane: assert property (p_byte_lane)
        else $error("byte lane wrong");
    property p_err_pulse;
        addr_error |=> !addr_error;
    endproperty
    a_err_pulse: assert property (p_err_pulse)
        else $error("trap flag not a pulse");
    property p_err_vector;
        $rose(addr_error) |-> ##[0:2] (prog_addr == `MCD_TRAP_VECTOR
            || prog_addr == `MCD_TRAP_VECTOR + 23'h2);
    endproperty
    a_err_vector: assert property (p_err_vector)
        else $error("trap vector not fetched");
    // Pulse may sit on the second push or the cycle after it; accept both placements
    property p_push_pair;
        $rose(addr_error) |-> (($past(dmem_we, 2) && $past(dmem_we)
            && $past(dmem_waddr) == $past(dmem_waddr, 2) + 16'h2)
            || (dmem_we && $past(dmem_we)
            && dmem_waddr == $past(dmem_waddr) + 16'h2));
    endproperty
    a_push_pair: assert property (p_push_pair)
        else $error("stack push not upward");
    c_trap: cover property ($rose(addr_error));
    c_psv: cover property (dmem_raddr[15]);
    c_byte: cover property (dmem_we && dmem_wbe == 2'b10);
endmodule // mcd_core_chk

bind mcd_core mcd_core_chk mcd_core_chk_inst (.pclk(pclk), .presetn(presetn),
    .prog_addr(prog_addr), .psv_addr(psv_addr), .dmem_raddr(dmem_raddr),
    .dmem_waddr(dmem_waddr), .dmem_we(dmem_we), .dmem_wbe(dmem_wbe),
    .addr_error(addr_error));

// File: tb/mcd_core_mem.sv
// Program and data memory model facing the core
module mcd_core_mem (
    input wire logic        pclk,
    input wire logic [22:0] prog_addr,
    output logic     [23:0] prog_rdata,
    input wire logic [22:0] psv_addr,
    output logic     [23:0] psv_rdata,
    input wire logic [15:0] dmem_raddr,
    output logic     [15:0] dmem_rdata,
    input wire logic [15:0] dmem_waddr,
    input wire logic [15:0] dmem_wdata,
    input wire logic        dmem_we,
    input wire logic [1:0]  dmem_wbe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only 32K program words modelled, enough for any test
    logic [23:0] prog_mem [0:32767];
    logic [15:0] data_mem [0:32767];
    initial
    begin
        for (int i = 0; i < 32768; i++)
        begin
            prog_mem[i] = 24'h000000;
            data_mem[i] = 16'h0000;
        end
    end
    assign prog_rdata = prog_mem[prog_addr[15:1]];
    assign psv_rdata  = prog_mem[psv_addr[15:1]];
    assign dmem_rdata = data_mem[dmem_raddr[15:1]];
    // Separate read and write ports so both fit one cycle
    always @(posedge pclk)
    begin
        if (dmem_we && dmem_wbe[0])
            data_mem[dmem_waddr[15:1]][7:0] <= dmem_wdata[7:0];
        if (dmem_we && dmem_wbe[1])
            data_mem[dmem_waddr[15:1]][15:8] <= dmem_wdata[15:8];
    end
endmodule // mcd_core_mem

// File: tb/mcd_core_test.sv
// Self-checking bench: register access and a checked program
`include "mcd_core_defines.vh"
module mcd_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, irq_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, r;
    logic e;
    wire  [31:0] prdata;
    wire  pready, pslverr, dmem_we, irq_ack, addr_error;
    wire  [22:0] prog_addr, psv_addr;
    wire  [23:0] prog_rdata, psv_rdata;
    wire  [15:0] dmem_raddr, dmem_rdata, dmem_waddr, dmem_wdata;
    wire  [1:0]  dmem_wbe;
    int fails = 0, cmp_count = 0, traps = 0, n;
    logic [23:0] code [0:34] = '{24'h400007, 0, 24'h600000, 0,
        24'h3f0116, 24'h1b00c3, 24'h3b01fe, 24'h40ffff,
        24'h121234, 24'h130005, 24'h002190, 24'h340100,
        24'h15fffe, 24'h160003, 24'h8c3b28, 24'h370102, 24'h380104,
        24'h843b28, 24'h380106, 24'h059028, 24'h320108,
        24'ha21028, 24'h33010a, 24'h32010c,
        24'h120064, 24'h140007, 24'h700011, 24'h900120,
        24'h300110, 24'h310112, 24'h298004, 24'h390114,
        24'h1c0119, 24'h05e02c, 24'h2a0121};
    mcd_core mcd_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata), .psv_addr(psv_addr),
        .psv_rdata(psv_rdata), .dmem_raddr(dmem_raddr),
        .dmem_rdata(dmem_rdata), .dmem_waddr(dmem_waddr),
        .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_wbe(dmem_wbe),
        .irq_req(irq_req), .irq_ack(irq_ack), .addr_error(addr_error));
    mcd_core_mem mcd_core_mem_inst (.pclk(pclk), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata), .psv_addr(psv_addr), .psv_rdata(psv_rdata),
        .dmem_raddr(dmem_raddr), .dmem_rdata(dmem_rdata),
        .dmem_waddr(dmem_waddr), .dmem_wdata(dmem_wdata),
        .dmem_we(dmem_we), .dmem_wbe(dmem_wbe));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk)
        if (addr_error === 1'b1)
            traps++;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Request held until pready is seen high at an edge
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function logic [31:0] mem(input logic [15:0] a);
        return {16'h0000, mcd_core_mem_inst.data_mem[a[15:1]]};
    endfunction
    initial
    begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        irq_req = 0; presetn = 0; r = 0; e = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (code[i]) mcd_core_mem_inst.prog_mem[i] = code[i];
        mcd_core_mem_inst.prog_mem[16'h4002] = 24'hab5a5a;
        apb(`MCD_REG_PVP, 1'b0, 32'h0);
        check(r, 32'h0);
        apb(`MCD_REG_PVP, 1'b1, 32'h1ff);
        apb(`MCD_REG_PVP, 1'b0, 32'h0);
        check(r, 32'hff);
        apb(12'h010, 1'b0, 32'h0);
        check({r[30:0], e}, 32'h1);
        apb(`MCD_REG_PVP, 1'b1, 32'h1);
        apb(`MCD_REG_CTRL, 1'b1, 32'h3);
        // Interrupt lands inside the divide loop, which must then resume
        do
        begin
            @(posedge pclk);
        end
        while (prog_addr !== 23'h000038);
        irq_req <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (irq_ack !== 1'b1);
        irq_req <= 1'b0;
        #1;
        check(mem(16'h0800), 32'h0036);
        check(mem(16'h0802), 32'h8000);
        for (n = 0; n < 3000; n++)
        begin
            @(negedge pclk);
            if (dmem_we === 1'b1 && dmem_waddr === 16'h01fe)
                break;
        end
        if (n == 3000)
            fails++;
        @(posedge pclk);
        #1;
        check(mem(16'h0100), 32'h1239);
        check(mem(16'h0102), 32'hfffa);
        check(mem(16'h0104), 32'hffff);
        check(mem(16'h0106), 32'h0002);
        check(mem(16'h0108), 32'h12fe);
        check(mem(16'h010a), 32'hfffe);
        check(mem(16'h010c), 32'h0000);
        check(mem(16'h0110), 32'h000e);
        check(mem(16'h0112), 32'h0002);
        check(mem(16'h0114), 32'h5a5a);
        check(mem(16'h0118), 32'hfe00);
        check(mem(16'h0116), 32'h0804);
        check(mem(16'h0800), 32'h0044);
        check(mem(16'h0802), 32'h0000);
        check(mem(16'h01fe), 32'h00c3);
        check(traps, 32'h1);
        wrap_up;
    end
    initial
    begin
        #60000;
        fails++;
        wrap_up;
    end
endmodule // mcd_core_test
